// file: flash_bank_model.sv
// Purpose: Behavioural flash bank that answers the sequencer's requests
// Assumes: One operation at a time; the bench sets latency and error injection
// Notes: A resumed operation restarts its full latency, which is the slow case
`timescale 1ns/1ps
module flash_bank_model
  import flash_command_sequencer_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire flash_cmd_s flashCmd,
  input wire logic suspendReq,
  input wire logic resumeReq,
  input wire logic stopReq,
  input wire logic [7:0] lat,
  input wire logic failNext,
  output logic flashDone,
  output logic flashError
);
  // ----------------------------------------------------------------
  // Operation timer
  // ----------------------------------------------------------------
  logic [7:0] left;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      left <= 8'h00;
      flashDone <= 1'b0;
      flashError <= 1'b0;
    end else begin
      flashDone <= 1'b0;
      flashError <= 1'b0;
      if (stopReq) begin
        left <= 8'h00;
      end else if (flashCmd.start || resumeReq) begin
        left <= lat;
      end else if (suspendReq) begin
        left <= 8'h02;
      end else if (left != 8'h00) begin
        left <= left - 8'h01;
        flashDone <= (left == 8'h01);
        // Error comes one cycle before done so it lands while busy
        flashError <= failNext && (left == 8'h02);
      end
    end
  end
endmodule : flash_bank_model

// file: flash_command_sequencer.sv
// Purpose: Mode entry, bank readability and command decoding for flash
// Assumes: Flash banks answer on the same clock with flashDone/flashError
// Notes: Address ranges and data flash unit boundaries are checked by the banks
// Function
// - Mode 0000: no commands, all flash readable
// - Mode 0001 on channel 0: code flash mode
// - Code mode busy: data flash unreadable
// - Only controlled code bank unreadable while busy
// - Mode 0080: controlled data bank unreadable busy
// - Both mode registers enter data mode independently
// - Program: 512 bytes user, 4 bytes data
// - Multi-program data only, 8/16/32 bytes
// - DMA program 4 bytes to 48K, data
// - Block erase one block; area erase N
// - Blank check data ranges, single unit
// - Suspend pauses program/erase; resume continues it
// - Status clear clears op and illegal errors; enable error and its lock stay
// - Forced stop aborts, resets the addressed channel's status
// - E8, count, words, D0 programming
// - ED, count 2/4/8, words, D0
// - EA, 16-bit count, words, no final
// - B0 suspend, D0 resume, 50, B3
// - 40/80/60, count 1 or 8, D0
// - Ready low on start; rise raises interrupt
// - Enables zero: commands refused, enable error set
// - Lock is OR of error flags
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module flash_command_sequencer
  import flash_command_sequencer_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output flash_cmd_s flashCmd,
  output logic wordValid,
  output logic [31:0] writeWord,
  output logic suspendReq,
  output logic resumeReq,
  output logic stopReq,
  input wire logic flashDone,
  input wire logic flashError,
  output logic readyIrq,
  output logic codeBankReadable,
  output logic otherCodeReadable,
  output logic dataBankReadable,
  output logic securityDataReadable
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic lockOf(input status_s s);
    lockOf = s.errOp | s.errIllegal | s.errEnable;
  endfunction : lockOf

  function automatic logic [31:0] statWord(input status_s s);
    statWord = 32'h0;
    statWord[SB_READY] = s.ready;
    statWord[SB_PRGSPD] = s.prgSpd;
    statWord[SB_ERSSPD] = s.ersSpd;
    statWord[SB_LOCK] = lockOf(s);
    statWord[SB_ERROP] = s.errOp;
    statWord[SB_ERRILL] = s.errIllegal;
    statWord[SB_ERREN] = s.errEnable;
  endfunction : statWord

  function automatic kind_e kindOf(input logic [7:0] b);
    if (b == OP_PROG) kindOf = K_PROG;
    else if (b == OP_MULTI) kindOf = K_MULTI;
    else if (b == OP_DMA) kindOf = K_DMA;
    else if (b == OP_BERASE) kindOf = K_BERASE;
    else if (b == OP_AERASE) kindOf = K_AERASE;
    else if (b == OP_BLANK) kindOf = K_BLANK;
    else if (b == OP_CFG) kindOf = K_CFG;
    else if (b == OP_PROT) kindOf = K_PROT;
    else if (b == OP_SEC) kindOf = K_SEC;
    else kindOf = K_NONE;
  endfunction : kindOf

  function automatic logic countOk(input kind_e k, input logic code, input logic [15:0] v);
    case (k)
      K_PROG: countOk = v == {8'h00, code ? CNT_USER : CNT_ONE};
      K_MULTI: countOk = v == {8'h00, CNT_TWO} || v == {8'h00, CNT_FOUR}
                         || v == {8'h00, CNT_EIGHT};
      K_DMA: countOk = v != 16'h0 && v <= DMA_MAX;
      default: countOk = v == {8'h00, CNT_ONE} || v == {8'h00, CNT_EIGHT};
    endcase
  endfunction : countOk

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_COUNT, S_WORDS, S_FINAL, S_CONFIRM} st_e;
  st_e state, next_state;
  kind_e kind, next_kind, opKind;
  logic chan, next_chan, opChan, suspending;
  logic [15:0] left, next_left, count, next_count;
  logic [15:0] mode [2];
  logic peA, peB;
  status_s stat [2];
  logic [1:0] prevReady;
  logic [1:0] setIll, setEn, doClr, doStop, doStart, doDone;
  logic doSusp, doRes, emitWord;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire cmdWr = regWrite && (regAddr == OFS_CMD0 || regAddr == OFS_CMD1);
  wire cw = regAddr == OFS_CMD1;
  wire [7:0] b = regWdata[7:0];
  wire [1:0] codeM = {1'b0, mode[0] == MODE_CODE};
  wire [1:0] dataM = {mode[1] == MODE_DATA, mode[0] == MODE_DATA};
  wire [1:0] inMode = codeM | dataM;
  wire peOk = peA && peB;
  wire status_s ts = stat[cw];
  wire kind_e kk = kindOf(b);
  wire kCode = kk == K_PROG || kk == K_BERASE;
  wire kOk = kk != K_NONE && (!codeM[cw] || kCode);
  wire isProg = kk == K_PROG || kk == K_MULTI || kk == K_DMA;
  wire suspOk = !suspending && !ts.prgSpd && !ts.ersSpd && opChan == cw
                && (opKind == K_PROG || opKind == K_MULTI
                    || opKind == K_BERASE || opKind == K_AERASE);
  wire [1:0] busy = {!stat[1].ready || stat[1].errEnable, !stat[0].ready || stat[0].errEnable};

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_chan = chan;
    next_left = left;
    next_count = count;
    setIll = 2'b00;
    setEn = 2'b00;
    doClr = 2'b00;
    doStop = 2'b00;
    doStart = 2'b00;
    doSusp = 1'b0;
    doRes = 1'b0;
    emitWord = 1'b0;
    if (cmdWr) begin
      case (state)
        S_IDLE: begin
          if (!inMode[cw]) begin
            next_state = S_IDLE;
          end else if (b == OP_STOP) begin
            doStop[cw] = 1'b1;
          end else if (b == OP_CLEAR) begin
            if (ts.ready) doClr[cw] = 1'b1;
            else setIll[cw] = 1'b1;
          end else if (lockOf(ts)) begin
            setIll[cw] = 1'b1;
          end else if (!peOk) begin
            setEn[cw] = 1'b1;
          end else if (!ts.ready) begin
            if (b == OP_SUSP && suspOk) doSusp = 1'b1;
            else setIll[cw] = 1'b1;
          end else if (ts.prgSpd || ts.ersSpd) begin
            if (b == OP_FINAL) doRes = 1'b1;
            else if (kOk && (kk == K_BLANK || (ts.ersSpd && isProg))) next_kind = kk;
            else setIll[cw] = 1'b1;
          end else if (kOk) begin
            next_kind = kk;
          end else begin
            setIll[cw] = 1'b1;
          end
          if (next_kind != K_NONE) begin
            next_chan = cw;
            if (kk == K_BERASE || kk == K_AERASE || kk == K_BLANK) next_state = S_CONFIRM;
            else next_state = S_COUNT;
          end
        end
        S_COUNT: begin
          next_count = kind == K_DMA ? regWdata[15:0] : {8'h00, b};
          next_left = next_count;
          if (countOk(kind, codeM[chan], next_count)) begin
            next_state = S_WORDS;
          end else begin
            setIll[chan] = 1'b1;
            next_state = S_IDLE;
            next_kind = K_NONE;
          end
        end
        S_WORDS: begin
          emitWord = 1'b1;
          next_left = left - 16'd1;
          if (left == 16'd1) begin
            if (kind == K_DMA) begin
              doStart[chan] = 1'b1;
              next_state = S_IDLE;
              next_kind = K_NONE;
            end else begin
              next_state = S_FINAL;
            end
          end
        end
        default: begin
          if (b == OP_FINAL) doStart[chan] = 1'b1;
          else setIll[chan] = 1'b1;
          next_state = S_IDLE;
          next_kind = K_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
      kind <= K_NONE;
      chan <= 1'b0;
      left <= 16'h0;
      count <= 16'h0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      chan <= next_chan;
      left <= next_left;
      count <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // Flash side
  // ----------------------------------------------------------------
  assign doDone = {flashDone && opChan && !stat[1].ready, flashDone && !opChan && !stat[0].ready};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flashCmd <= '0;
      wordValid <= 1'b0;
      writeWord <= 32'h0;
      suspendReq <= 1'b0;
      resumeReq <= 1'b0;
      stopReq <= 1'b0;
      opKind <= K_NONE;
      opChan <= 1'b0;
      suspending <= 1'b0;
    end else begin
      flashCmd.start <= |doStart;
      wordValid <= emitWord;
      suspendReq <= doSusp;
      resumeReq <= doRes;
      stopReq <= |doStop;
      if (emitWord) writeWord <= regWdata;
      if (|doStart) begin
        flashCmd.kind <= kind;
        flashCmd.chan <= chan;
        flashCmd.count <= count;
        opKind <= kind;
        opChan <= chan;
      end
      if (doSusp) suspending <= 1'b1;
      else if (|doDone || |doStop) suspending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status, one per channel
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stat[0] <= STAT_RST;
      stat[1] <= STAT_RST;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (doStop[c]) begin
          stat[c] <= STAT_RST;
        end else begin
          // Clear first so a same-cycle error still lands
          if (doClr[c]) begin
            stat[c].errOp <= 1'b0;
            stat[c].errIllegal <= 1'b0;
          end
          if (doStart[c]) stat[c].ready <= 1'b0;
          if (doRes && c == int'(opChan)) begin
            stat[c].ready <= 1'b0;
            stat[c].prgSpd <= 1'b0;
            stat[c].ersSpd <= 1'b0;
          end
          if (doDone[c]) begin
            stat[c].ready <= 1'b1;
            if (suspending) begin
              stat[c].prgSpd <= opKind == K_PROG || opKind == K_MULTI;
              stat[c].ersSpd <= opKind == K_BERASE || opKind == K_AERASE;
            end
          end
          if (flashError && c == int'(opChan) && !stat[c].ready) stat[c].errOp <= 1'b1;
          if (setIll[c]) stat[c].errIllegal <= 1'b1;
          if (setEn[c]) stat[c].errEnable <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) prevReady <= 2'b11;
    else prevReady <= {stat[1].ready, stat[0].ready};
  end

  assign readyIrq = |({stat[1].ready, stat[0].ready} & ~prevReady);

  // ----------------------------------------------------------------
  // Bank readability
  // ----------------------------------------------------------------
  assign codeBankReadable = !(codeM[0] && busy[0]);
  assign otherCodeReadable = 1'b1;
  assign dataBankReadable = !(inMode[0] && busy[0]);
  assign securityDataReadable = !(dataM[1] && busy[1]);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode[0] <= MODE_READ;
      mode[1] <= MODE_READ;
      peA <= 1'b0;
      peB <= 1'b0;
    end else if (regWrite) begin
      // Undefined mode values are dropped to keep the mode decode one-hot
      if (regAddr == OFS_MODE0 && (regWdata[15:0] == MODE_READ
          || regWdata[15:0] == MODE_CODE || regWdata[15:0] == MODE_DATA)) begin
        mode[0] <= regWdata[15:0];
      end else if (regAddr == OFS_MODE1 && (regWdata[15:0] == MODE_READ
          || regWdata[15:0] == MODE_DATA)) begin
        mode[1] <= regWdata[15:0];
      end else if (regAddr == OFS_PEA) begin
        peA <= regWdata[0];
      end else if (regAddr == OFS_PEB) begin
        peB <= regWdata[0];
      end
    end
  end

  wire [31:0] rdMux = regAddr == OFS_MODE0 ? {16'h0, mode[0]}
                    : regAddr == OFS_MODE1 ? {16'h0, mode[1]}
                    : regAddr == OFS_PEA ? {31'h0, peA}
                    : regAddr == OFS_PEB ? {31'h0, peB}
                    : regAddr == OFS_STAT0 ? statWord(stat[0])
                    : regAddr == OFS_STAT1 ? statWord(stat[1]) : 32'h0;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) regRdata <= 32'h0;
    else if (regRead) regRdata <= rdMux;
    else regRdata <= 32'h0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seqConfirm;
    cmdWr && (state == S_CONFIRM || state == S_FINAL) && b == OP_FINAL;
  endsequence
  sequence seqBadFinal;
    cmdWr && (state == S_CONFIRM || state == S_FINAL) && b != OP_FINAL;
  endsequence

  startReady_a: assert property (@(posedge clock) disable iff (!nrst)
    flashCmd.start |-> !stat[flashCmd.chan].ready) else $error("ready high at start");
  readyIrq_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(stat[0].ready) || $rose(stat[1].ready) |-> readyIrq) else $error("no ready interrupt");
  readMode_a: assert property (@(posedge clock) disable iff (!nrst)
    (cmdWr && state == S_IDLE && !inMode[cw]) |=> state == S_IDLE && !flashCmd.start)
    else $error("command taken in read mode");
  lockHold_a: assert property (@(posedge clock) disable iff (!nrst)
    (cmdWr && state == S_IDLE && !cw && lockOf(stat[0]) && b != OP_STOP && b != OP_CLEAR)
    |=> state == S_IDLE) else $error("command taken while locked");
  peError_a: assert property (@(posedge clock) disable iff (!nrst)
    (cmdWr && state == S_IDLE && !cw && inMode[0] && !peOk && !lockOf(stat[0])
     && b == OP_BERASE) |=> stat[0].errEnable && state == S_IDLE)
    else $error("enable error missing");
  userCount_a: assert property (@(posedge clock) disable iff (!nrst)
    (flashCmd.start && flashCmd.kind == K_PROG && !flashCmd.chan && codeM[0])
    |-> flashCmd.count == 16'h0080) else $error("user program count wrong");
  dmaRange_a: assert property (@(posedge clock) disable iff (!nrst)
    (flashCmd.start && flashCmd.kind == K_DMA) |-> flashCmd.count inside {[1:12288]})
    else $error("dma count out of range");
  stopReset_a: assert property (@(posedge clock) disable iff (!nrst)
    (cmdWr && state == S_IDLE && !cw && inMode[0] && b == OP_STOP)
    |=> stat[0] == STAT_RST && stopReq) else $error("forced stop incomplete");
  confirm_a: assert property (@(posedge clock) disable iff (!nrst)
    seqConfirm |=> flashCmd.start) else $error("confirm did not start");
  badFinal_a: assert property (@(posedge clock) disable iff (!nrst)
    seqBadFinal |=> !flashCmd.start && stat[$past(chan)].errIllegal)
    else $error("bad final not locked");
  codeBusy_a: assert property (@(posedge clock) disable iff (!nrst)
    (codeM[0] && !stat[0].ready) |-> !codeBankReadable && !dataBankReadable)
    else $error("bank readable while busy");
endmodule : flash_command_sequencer

// file: flash_command_sequencer_pkg.sv
// Purpose: Shared constants and types for the flash command sequencer
// Assumes: 32-bit register port, two sequencer channels
// Notes: Channel 1 serves the security module data flash
package flash_command_sequencer_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE0 = 8'h00;
  localparam logic [7:0] OFS_MODE1 = 8'h04;
  localparam logic [7:0] OFS_PEA = 8'h08;
  localparam logic [7:0] OFS_PEB = 8'h0c;
  localparam logic [7:0] OFS_STAT0 = 8'h10;
  localparam logic [7:0] OFS_STAT1 = 8'h14;
  localparam logic [7:0] OFS_CMD0 = 8'h20;
  localparam logic [7:0] OFS_CMD1 = 8'h24;
  // ----------------------------------------------------------------
  // Modes, opcodes, counts
  // ----------------------------------------------------------------
  localparam logic [15:0] MODE_READ = 16'h0000;
  localparam logic [15:0] MODE_CODE = 16'h0001;
  localparam logic [15:0] MODE_DATA = 16'h0080;
  localparam logic [7:0] OP_PROG = 8'he8;
  localparam logic [7:0] OP_MULTI = 8'hed;
  localparam logic [7:0] OP_DMA = 8'hea;
  localparam logic [7:0] OP_BERASE = 8'h20;
  localparam logic [7:0] OP_AERASE = 8'h23;
  localparam logic [7:0] OP_BLANK = 8'h71;
  localparam logic [7:0] OP_SUSP = 8'hb0;
  localparam logic [7:0] OP_FINAL = 8'hd0;
  localparam logic [7:0] OP_CLEAR = 8'h50;
  localparam logic [7:0] OP_STOP = 8'hb3;
  localparam logic [7:0] OP_CFG = 8'h40;
  localparam logic [7:0] OP_PROT = 8'h80;
  localparam logic [7:0] OP_SEC = 8'h60;
  localparam logic [7:0] CNT_USER = 8'h80;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_TWO = 8'h02;
  localparam logic [7:0] CNT_FOUR = 8'h04;
  localparam logic [7:0] CNT_EIGHT = 8'h08;
  localparam logic [15:0] DMA_MAX = 16'h3000;
  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int SB_READY = 15;
  localparam int SB_PRGSPD = 14;
  localparam int SB_ERSSPD = 13;
  localparam int SB_LOCK = 12;
  localparam int SB_ERROP = 2;
  localparam int SB_ERRILL = 1;
  localparam int SB_ERREN = 0;

  typedef enum logic [3:0] {
    K_NONE, K_PROG, K_MULTI, K_DMA, K_BERASE, K_AERASE, K_BLANK, K_CFG, K_PROT, K_SEC
  } kind_e;

  typedef struct packed {
    logic ready;
    logic prgSpd;
    logic ersSpd;
    logic errOp;
    logic errIllegal;
    logic errEnable;
  } status_s;

  localparam status_s STAT_RST = '{ready: 1'b1, default: 1'b0};

  typedef struct packed {
    logic start;
    kind_e kind;
    logic chan;
    logic [15:0] count;
  } flash_cmd_s;
endpackage : flash_command_sequencer_pkg

// file: tb_top.sv
// Purpose: Self-checking bench for the flash command sequencer
// Assumes: Register port driven by non-blocking assignment after rising edges
// Notes: Pulses are counted by a monitor so checks do not depend on exact cycles
`timescale 1ns/1ps
module tb_top;
  import flash_command_sequencer_pkg::*;
  logic clock, nrst, regWrite, regRead, wordValid, suspendReq, resumeReq, stopReq;
  logic flashDone, flashError, readyIrq, failNext, ch;
  logic codeBankReadable, otherCodeReadable, dataBankReadable, securityDataReadable;
  logic [7:0] regAddr, lat;
  logic [31:0] regWdata, regRdata, writeWord, rv, lastWord;
  flash_cmd_s flashCmd, lastCmd;
  int n_mismatch = 0, n_compared = 0, nStart = 0, nWord = 0, nIrq = 0;
  int nSusp = 0, nRes = 0, nStop = 0;
  flash_command_sequencer flash_command_sequencer_i (.clock(clock), .nrst(nrst),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .flashCmd(flashCmd), .wordValid(wordValid), .writeWord(writeWord),
    .suspendReq(suspendReq), .resumeReq(resumeReq), .stopReq(stopReq),
    .flashDone(flashDone), .flashError(flashError), .readyIrq(readyIrq),
    .codeBankReadable(codeBankReadable), .otherCodeReadable(otherCodeReadable),
    .dataBankReadable(dataBankReadable), .securityDataReadable(securityDataReadable));
  flash_bank_model flash_bank_model_i (.clock(clock), .nrst(nrst), .flashCmd(flashCmd),
    .suspendReq(suspendReq), .resumeReq(resumeReq), .stopReq(stopReq), .lat(lat),
    .failNext(failNext), .flashDone(flashDone), .flashError(flashError));
  // ----------------------------------------------------------------
  // Clock and pulse monitor
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (flashCmd.start === 1'b1) begin
      nStart++;
      lastCmd = flashCmd;
    end
    if (wordValid === 1'b1) begin
      nWord++;
      lastWord = writeWord;
    end
    nIrq += int'(readyIrq === 1'b1);
    nSusp += int'(suspendReq === 1'b1);
    nRes += int'(resumeReq === 1'b1);
    nStop += int'(stopReq === 1'b1);
  end
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    d = regRdata;
  endtask : rd
  task automatic cmd(input logic [7:0] b);
    wr(ch ? OFS_CMD1 : OFS_CMD0, {24'h0, b});
  endtask : cmd
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, rv);
    chk($sformatf("reg %h", a), rv, exp);
  endtask : rchk
  task automatic wait_ready();
    int i;
    rv = 32'h0;
    for (i = 0; i < 100 && rv[15] !== 1'b1; i++) rd(ch ? OFS_STAT1 : OFS_STAT0, rv);
    chk("ready", {31'h0, rv[15]}, 32'h1);
    repeat (3) @(posedge clock);
  endtask : wait_ready
  // Issues one full command; n of zero means the form without count and words
  task automatic run(input logic [7:0] op, input logic [15:0] n, input kind_e k,
                     input logic fin, input logic [3:0] busyRd);
    int s0, w0, q0, i;
    s0 = nStart;
    w0 = nWord;
    q0 = nIrq;
    cmd(op);
    if (n != 16'h0) wr(ch ? OFS_CMD1 : OFS_CMD0, {16'h0, n});
    for (i = 0; i < int'(n); i++) wr(OFS_CMD0, 32'hc0de0000 + i);
    if (fin) cmd(OP_FINAL);
    repeat (2) @(negedge clock);
    chk("starts", nStart, s0 + 1);
    chk("kind", 32'(lastCmd.kind), 32'(k));
    chk("chan", {31'h0, lastCmd.chan}, {31'h0, ch});
    chk("readable", {codeBankReadable, otherCodeReadable, dataBankReadable,
        securityDataReadable}, 32'(busyRd));
    if (n != 16'h0) chk("count", 32'(lastCmd.count), 32'(n));
    chk("words", nWord, w0 + int'(n));
    if (n != 16'h0) chk("last word", lastWord, 32'hc0de0000 + n - 1);
    wait_ready();
    chk("irq", nIrq, q0 + 1);
    chk("idle readable", {codeBankReadable, otherCodeReadable, dataBankReadable,
        securityDataReadable}, 32'hf);
  endtask : run
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    $display("watchdog expired");
    tally_and_finish();
  end
  initial begin
    static logic [7:0] addrs[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h30};
    static logic [31:0] rst[8] = '{0, 0, 0, 0, 32'h8000, 32'h8000, 0, 0};
    static logic [7:0] multi[3] = '{CNT_TWO, CNT_FOUR, CNT_EIGHT};
    int k;
    nrst = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    lat = 8'h08;
    failNext = 1'b0;
    ch = 1'b0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    for (k = 0; k < 8; k++) rchk(addrs[k], rst[k]);
    cmd(OP_BERASE);
    cmd(OP_FINAL);
    rchk(OFS_STAT0, 32'h8000);
    chk("no start", nStart, 0);
    $display("test reset and read mode done");
    wr(OFS_MODE0, 32'h0080);
    rchk(OFS_MODE0, 32'h0080);
    cmd(OP_BERASE);
    rchk(OFS_STAT0, 32'h9001);
    cmd(OP_CLEAR);
    rchk(OFS_STAT0, 32'h9001);
    cmd(OP_STOP);
    rchk(OFS_STAT0, 32'h8000);
    chk("stops", nStop, 1);
    wr(OFS_PEA, 32'h1);
    wr(OFS_PEB, 32'h1);
    rchk(OFS_PEB, 32'h1);
    $display("test enables done");
    run(OP_PROG, 16'h1, K_PROG, 1'b1, 4'b1101);
    for (k = 0; k < 3; k++) run(OP_MULTI, {8'h0, multi[k]}, K_MULTI, 1'b1, 4'b1101);
    run(OP_BERASE, 16'h0, K_BERASE, 1'b1, 4'b1101);
    run(OP_AERASE, 16'h0, K_AERASE, 1'b1, 4'b1101);
    run(OP_BLANK, 16'h0, K_BLANK, 1'b1, 4'b1101);
    run(OP_CFG, 16'h1, K_CFG, 1'b1, 4'b1101);
    run(OP_PROT, 16'h8, K_PROT, 1'b1, 4'b1101);
    run(OP_SEC, 16'h1, K_SEC, 1'b1, 4'b1101);
    run(OP_DMA, 16'h3, K_DMA, 1'b0, 4'b1101);
    $display("test data mode commands done");
    cmd(OP_MULTI);
    cmd(8'h03);
    rchk(OFS_STAT0, 32'h9002);
    cmd(OP_BERASE);
    rchk(OFS_STAT0, 32'h9002);
    cmd(OP_CLEAR);
    rchk(OFS_STAT0, 32'h8000);
    cmd(OP_BERASE);
    cmd(8'h00);
    rchk(OFS_STAT0, 32'h9002);
    cmd(OP_CLEAR);
    chk("no bad start", nStart, 11);
    failNext <= 1'b1;
    run(OP_PROG, 16'h1, K_PROG, 1'b1, 4'b1101);
    failNext <= 1'b0;
    rchk(OFS_STAT0, 32'h9004);
    cmd(OP_CLEAR);
    rchk(OFS_STAT0, 32'h8000);
    $display("test errors done");
    lat <= 8'h3c;
    cmd(OP_BERASE);
    cmd(OP_FINAL);
    cmd(OP_SUSP);
    repeat (6) @(posedge clock);
    chk("suspends", nSusp, 1);
    rchk(OFS_STAT0, 32'ha000);
    cmd(OP_FINAL);
    rchk(OFS_STAT0, 32'h0000);
    chk("resumes", nRes, 1);
    wait_ready();
    rchk(OFS_STAT0, 32'h8000);
    cmd(OP_PROG);
    cmd(CNT_ONE);
    wr(OFS_CMD0, 32'h5a5a5a5a);
    cmd(OP_FINAL);
    cmd(OP_STOP);
    repeat (3) @(negedge clock);
    chk("stop busy", nStop, 2);
    rchk(OFS_STAT0, 32'h8000);
    lat <= 8'h08;
    $display("test suspend and stop done");
    wr(OFS_MODE0, 32'h0002);
    rchk(OFS_MODE0, 32'h0080);
    wr(OFS_MODE0, 32'h0001);
    run(OP_PROG, 16'h0080, K_PROG, 1'b1, 4'b0101);
    cmd(OP_MULTI);
    rchk(OFS_STAT0, 32'h9002);
    cmd(OP_CLEAR);
    wr(OFS_MODE0, 32'h0080);
    wr(OFS_MODE1, 32'h0001);
    rchk(OFS_MODE1, 32'h0000);
    wr(OFS_MODE1, 32'h0080);
    ch = 1'b1;
    run(OP_PROG, 16'h1, K_PROG, 1'b1, 4'b1110);
    rchk(OFS_STAT0, 32'h8000);
    $display("test code mode and dual mode done");
    tally_and_finish();
  end
endmodule : tb_top
